// ==== core/sild_map.vh ====
`ifndef SILD_MAP_VH
`define SILD_MAP_VH
// Indicator configuration register, MDIO address 20
`define SILD_CFG_ADDR         5'h14
`define SILD_CFG_RESET        16'h0422
`define SILD_FIRST_MSB        15
`define SILD_FIRST_LSB        12
`define SILD_SECOND_MSB       11
`define SILD_SECOND_LSB       8
`define SILD_THIRD_MSB        7
`define SILD_THIRD_LSB        4
`define SILD_DUR_MSB          3
`define SILD_DUR_LSB          2
`define SILD_STRETCH_EN_BIT   1
`define SILD_WRITE_MASK       16'hfffe
// Source select codes
`define SILD_SEL_SPEED        4'h0
`define SILD_SEL_TX           4'h1
`define SILD_SEL_RX           4'h2
`define SILD_SEL_COL          4'h3
`define SILD_SEL_LINK         4'h4
`define SILD_SEL_DUPLEX       4'h5
`define SILD_SEL_ACT          4'h7
`define SILD_SEL_ON           4'h8
`define SILD_SEL_OFF          4'h9
`define SILD_SEL_FAST         4'ha
`define SILD_SEL_SLOW         4'hb
`define SILD_SEL_LINK_RX      4'hc
`define SILD_SEL_LINK_ACT     4'hd
`define SILD_SEL_DUP_COL      4'he
// Timing, clock in kHz, times in ms
`define SILD_CLK_KHZ          25000
`define SILD_T30_MS           30
`define SILD_T60_MS           60
`define SILD_T100_MS          100
`define SILD_CYC30            (`SILD_T30_MS * `SILD_CLK_KHZ)
`define SILD_CYC60            (`SILD_T60_MS * `SILD_CLK_KHZ)
`define SILD_CYC100           (`SILD_T100_MS * `SILD_CLK_KHZ)
`define SILD_FAST_HALF_MS     50
`define SILD_SLOW_HALF_MS     250
`define SILD_CYC_FAST         (`SILD_FAST_HALF_MS * `SILD_CLK_KHZ)
`define SILD_CYC_SLOW         (`SILD_SLOW_HALF_MS * `SILD_CLK_KHZ)
`endif

// ==== core/sild_channel.v ====
`timescale 1ns/1ps
`include "sild_map.vh"
module sild_channel #(
	parameter CW = 32
) (
	input  wire          clk,       // System clock
	input  wire          rst_n,     // Synchronised reset
	input  wire [3:0]    sel,       // Source select
	input  wire          stretch_en,// Global stretch enable
	input  wire [CW-1:0] hold_cyc,  // Stretch length in cycles
	input  wire          speed,     // 100 Mb/s
	input  wire          tx,        // Transmit event
	input  wire          rx,        // Receive event
	input  wire          col,       // Collision event
	input  wire          link,      // Link up
	input  wire          duplex,    // Full duplex
	input  wire          fast_blink,// Fast test pattern
	input  wire          slow_blink,// Slow test pattern
	output reg           led_q      // Indicator state, high is lit
);
	reg  [CW-1:0] cnt_q;
	reg           blink_q;
	reg           ev;
	reg           combined;
	reg           primary;
	wire          busy;
	reg           led_d;

	always @*
	begin
		ev       = 1'b0;
		combined = 1'b0;
		primary  = 1'b0;
		case (sel)
			`SILD_SEL_TX:       ev = tx;
			`SILD_SEL_RX:       ev = rx;
			`SILD_SEL_COL:      ev = col;
			`SILD_SEL_ACT:      ev = tx | rx;
			`SILD_SEL_LINK_RX:
			begin
				ev       = rx;
				combined = 1'b1;
				primary  = link;
			end
			`SILD_SEL_LINK_ACT:
			begin
				ev       = tx | rx;
				combined = 1'b1;
				primary  = link;
			end
			`SILD_SEL_DUP_COL:
			begin
				ev       = col;
				combined = 1'b1;
				primary  = duplex;
			end
			default:            ev = 1'b0;
		endcase
	end

	// Counter restarts on every event while stretch is enabled; combined modes ignore the enable
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= {CW{1'b0}};
		else if (ev && (stretch_en || combined))
			cnt_q <= hold_cyc;
		else if (cnt_q != {CW{1'b0}})
			cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
	end
	assign busy = (cnt_q != {CW{1'b0}}) || ev;

	// Toggle at each window end, which steady traffic restarting the count never reaches;
	// also on a load that meets the last count, and then that window shows no change
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			blink_q <= 1'b0;
		else if (combined && cnt_q == {{(CW-1){1'b0}}, 1'b1})
			blink_q <= ~blink_q;
		else if (cnt_q == {CW{1'b0}})
			blink_q <= 1'b0;
	end

	always @*
	begin
		case (sel)
			`SILD_SEL_SPEED:    led_d = speed;
			`SILD_SEL_LINK:     led_d = link;
			`SILD_SEL_DUPLEX:   led_d = duplex;
			`SILD_SEL_TX, `SILD_SEL_RX, `SILD_SEL_COL, `SILD_SEL_ACT:
				led_d = stretch_en ? busy : ev;
			`SILD_SEL_ON:       led_d = 1'b1;
			`SILD_SEL_OFF:      led_d = 1'b0;
			`SILD_SEL_FAST:     led_d = fast_blink;
			`SILD_SEL_SLOW:     led_d = slow_blink;
			`SILD_SEL_LINK_RX, `SILD_SEL_LINK_ACT, `SILD_SEL_DUP_COL:
				led_d = busy ? (primary ^ ~blink_q) : primary;
			default:            led_d = 1'b0;
		endcase
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			led_q <= 1'b0;
		else
			led_q <= led_d;
	end
endmodule

// ==== core/sild_top.v ====
`timescale 1ns/1ps
`include "sild_map.vh"
module sild_top #(
	parameter CW        = 32,
	parameter CYC30     = `SILD_CYC30,
	parameter CYC60     = `SILD_CYC60,
	parameter CYC100    = `SILD_CYC100,
	parameter CYC_FAST  = `SILD_CYC_FAST,
	parameter CYC_SLOW  = `SILD_CYC_SLOW
) (
	input  wire        SYS_CLK,     // 25 MHz clock
	input  wire        ARST_N,      // Async reset, active low
	input  wire        REG_WE,      // Register write strobe
	input  wire [4:0]  REG_ADDR,    // Register address
	input  wire [15:0] REG_WDATA,   // Write data
	output reg  [15:0] REG_RDATA,   // Read data
	input  wire        SPEED_100,   // Speed status
	input  wire        TX_EVENT,    // Transmit activity
	input  wire        RX_EVENT,    // Receive activity
	input  wire        COL_EVENT,   // Collision
	input  wire        LINK_UP,     // Link status
	input  wire        FULL_DUPLEX, // Duplex status
	output wire [2:0]  LED_OUT      // Indicators 1..3, high is lit
);
	reg  [1:0]    rst_sync_q;
	wire          rst_n;
	reg  [15:0]   cfg_q;
	reg  [CW-1:0] fast_cnt_q;
	reg  [CW-1:0] slow_cnt_q;
	reg           fast_q;
	reg           slow_q;
	reg  [CW-1:0] hold_cyc;
	wire [3:0]    sel [0:2];

	////////////////////////////////////////////////////////////////////////
	always @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////
	// Bit 0 kept at zero so a careless write cannot disturb reads
	always @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			cfg_q <= `SILD_CFG_RESET;
		else if (REG_WE && REG_ADDR == `SILD_CFG_ADDR)
			cfg_q <= REG_WDATA & `SILD_WRITE_MASK;
	end

	always @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			REG_RDATA <= 16'h0000;
		else if (REG_ADDR == `SILD_CFG_ADDR)
			REG_RDATA <= cfg_q;
		else
			REG_RDATA <= 16'h0000;
	end

	// Reserved code 11 falls back to the shortest stretch
	always @*
	begin
		case (cfg_q[`SILD_DUR_MSB:`SILD_DUR_LSB])
			2'h1:    hold_cyc = CYC60[CW-1:0];
			2'h2:    hold_cyc = CYC100[CW-1:0];
			default: hold_cyc = CYC30[CW-1:0];
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fast_cnt_q <= {CW{1'b0}};
			slow_cnt_q <= {CW{1'b0}};
			fast_q     <= 1'b0;
			slow_q     <= 1'b0;
		end
		else
		begin
			if (fast_cnt_q >= CYC_FAST[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
			begin
				fast_cnt_q <= {CW{1'b0}};
				fast_q     <= ~fast_q;
			end
			else
				fast_cnt_q <= fast_cnt_q + {{(CW-1){1'b0}}, 1'b1};
			if (slow_cnt_q >= CYC_SLOW[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
			begin
				slow_cnt_q <= {CW{1'b0}};
				slow_q     <= ~slow_q;
			end
			else
				slow_cnt_q <= slow_cnt_q + {{(CW-1){1'b0}}, 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign sel[0] = cfg_q[`SILD_FIRST_MSB:`SILD_FIRST_LSB];
	assign sel[1] = cfg_q[`SILD_SECOND_MSB:`SILD_SECOND_LSB];
	assign sel[2] = cfg_q[`SILD_THIRD_MSB:`SILD_THIRD_LSB];

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_ch
			sild_channel #(
				.CW (CW)
			) u_ch (
				.clk        (SYS_CLK),
				.rst_n      (rst_n),
				.sel        (sel[gi]),
				.stretch_en (cfg_q[`SILD_STRETCH_EN_BIT]),
				.hold_cyc   (hold_cyc),
				.speed      (SPEED_100),
				.tx         (TX_EVENT),
				.rx         (RX_EVENT),
				.col        (COL_EVENT),
				.link       (LINK_UP),
				.duplex     (FULL_DUPLEX),
				.fast_blink (fast_q),
				.slow_blink (slow_q),
				.led_q      (LED_OUT[gi])
			);
		end
	endgenerate
endmodule

// ==== tb/sild_lamps.sv ====
`timescale 1ns/1ps
// Lamp bank: a lamp glows only while its line is high
module sild_lamps (
	input  wire [2:0] drive, // Indicator lines
	output wire [2:0] lit    // Lamp states
);
	assign lit = drive;
endmodule

// ==== tb/sild_checker.sv ====
`timescale 1ns/1ps
module sild_checker #(
	parameter CYC100 = 60
) (
	input wire        SYS_CLK,     // Clock
	input wire        ARST_N,      // Reset
	input wire        REG_WE,      // Write
	input wire [4:0]  REG_ADDR,    // Address
	input wire [15:0] REG_WDATA,   // Write data
	input wire [15:0] REG_RDATA,   // Read data
	input wire        SPEED_100,   // Speed
	input wire        TX_EVENT,    // Transmit
	input wire        RX_EVENT,    // Receive
	input wire        COL_EVENT,   // Collision
	input wire        LINK_UP,     // Link
	input wire        FULL_DUPLEX, // Duplex
	input wire [2:0]  LED_OUT      // Indicators
);
	localparam LIM = CYC100 + 10;
	reg [15:0] cfg_q;
	reg [1:0]  age_q;
	reg [31:0] quiet_q;
	wire [3:0] s    = cfg_q[7:4];
	wire       rdy  = age_q == 2'h3;
	wire       comb = s >= 4'hc && s <= 4'he;
	wire       prim = s == 4'he ? FULL_DUPLEX : LINK_UP;
	wire       sec  = s == 4'hc ? RX_EVENT : s == 4'hd ? TX_EVENT | RX_EVENT : COL_EVENT;
	wire       cont = s == 4'h0 || s == 4'h4 || s == 4'h5;
	wire       csrc = s == 4'h0 ? SPEED_100 : s == 4'h4 ? LINK_UP : FULL_DUPLEX;
	////////////////////////////////
	// Shadow config; internal reset lags the pin by two edges
	always @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			cfg_q <= 16'h0422;
			age_q <= 2'h0;
			quiet_q <= 32'h0;
		end
		else
		begin
			if (REG_WE && REG_ADDR == 5'h14)
				cfg_q <= REG_WDATA & 16'hfffe;
			if (!rdy)
				age_q <= age_q + 2'h1;
			if (!comb || sec || REG_WE || $changed(prim))
				quiet_q <= 32'h0;
			else if (quiet_q != LIM)
				quiet_q <= quiet_q + 32'h1;
		end
	end
	////////////////////////////////
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_quiet_read;
		(rdy && REG_ADDR == 5'h14 && !REG_WE)[*2];
	endsequence
	sequence s_comb_hit;
		rdy && comb && sec && quiet_q == LIM;
	endsequence
	sequence s_tx_hit;
		rdy && s == 4'h1 && cfg_q[1] && TX_EVENT;
	endsequence
	a_read_back: assert property (s_quiet_read |-> REG_RDATA == cfg_q)
		else $error("read data differs from register");
	a_bit0_zero: assert property (rdy |-> !REG_RDATA[0])
		else $error("bit 0 reads as one");
	a_force_level: assert property ((rdy && s[3:1] == 3'h4)[*2] |->
		LED_OUT[2] == !$past(s[0]))
		else $error("forced level wrong");
	a_unused_dark: assert property ((rdy && s == 4'hf)[*2] |-> !LED_OUT[2])
		else $error("unused code lit");
	a_cont_src: assert property ((rdy && cont)[*2] |-> LED_OUT[2] == $past(csrc))
		else $error("continuous source wrong");
	a_rx_plain: assert property ((rdy && s == 4'h2 && !cfg_q[1])[*2] |-> LED_OUT[2] == $past(RX_EVENT))
		else $error("unstretched receive wrong");
	a_act_any: assert property (rdy && s == 4'h7 && (TX_EVENT || RX_EVENT) |=> LED_OUT[2])
		else $error("activity not shown");
	a_tx_stretch: assert property (s_tx_hit |=> (LED_OUT[2] || s != 4'h1 || !cfg_q[1])[*8])
		else $error("stretch ended early");
	a_comb_rest: assert property (rdy && comb && quiet_q == LIM |-> LED_OUT[2] == $past(prim))
		else $error("combined rest level wrong");
	a_comb_blink: assert property (s_comb_hit |-> ##[1:2] LED_OUT[2] != prim)
		else $error("combined event no blink");
	a_comb_hold: assert property (s_comb_hit |=>
		(LED_OUT[2] != $past(prim) || !comb || REG_WE || $past(REG_WE))[*8])
		else $error("combined event not stretched");
endmodule
bind sild_top sild_checker #(.CYC100(CYC100)) i_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
	.REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.SPEED_100(SPEED_100), .TX_EVENT(TX_EVENT), .RX_EVENT(RX_EVENT), .COL_EVENT(COL_EVENT),
	.LINK_UP(LINK_UP), .FULL_DUPLEX(FULL_DUPLEX), .LED_OUT(LED_OUT));

// ==== tb/test_sild_top.sv ====
`timescale 1ns/1ps
module test_sild_top;
	localparam C30 = 20, C60 = 40, C100 = 60, CF = 8, CS = 16;
	reg        clk, rst_n, we, spd, tx, rx, col, lnk, dup, b;
	reg [4:0]  addr;
	reg [15:0] wd, v;
	reg [31:0] seed;
	wire [15:0] rd;
	wire [2:0] led, lit;
	integer    error_cnt, comparisons, i, j, n, lo;
	integer    cyc = 0;
	sild_top #(.CYC30(C30), .CYC60(C60), .CYC100(C100), .CYC_FAST(CF), .CYC_SLOW(CS)) i_dut (
		.SYS_CLK(clk), .ARST_N(rst_n), .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wd),
		.REG_RDATA(rd), .SPEED_100(spd), .TX_EVENT(tx), .RX_EVENT(rx), .COL_EVENT(col),
		.LINK_UP(lnk), .FULL_DUPLEX(dup), .LED_OUT(led));
	sild_lamps i_lamps (.drive(led), .lit(lit));
	////////////////////////////////
	function [31:0] xs(input [31:0] x);
	begin
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	end
	endfunction
	task chk(input [15:0] got, input [15:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [15:0] d);
	begin
		@(posedge clk);
		we <= 1'b1;
		addr <= 5'h14;
		wd <= d;
		@(posedge clk);
		we <= 1'b0;
		repeat (2) @(posedge clk);
	end
	endtask
	task rd_chk(input [4:0] a, input [15:0] exp);
	begin
		@(posedge clk);
		addr <= a;
		repeat (2) @(posedge clk);
		#1 chk(rd, exp);
	end
	endtask
	// Sparse events so combined displays see quiet spells
	task rnd_run(input integer cycles);
	begin
		repeat (cycles)
		begin
			seed = xs(seed);
			tx <= seed[4:0] == 5'h0;
			rx <= seed[9:5] == 5'h0;
			col <= seed[14:10] == 5'h0;
			lnk <= lnk ^ (seed[22:15] == 8'h0);
			dup <= dup ^ (seed[30:23] == 8'h0);
			@(posedge clk);
		end
	end
	endtask
	task conclude;
	begin
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt = error_cnt + 1;
			$display("ERROR %0t timeout", $time);
			conclude;
		end
	end
	initial
	begin
		{rst_n, we, spd, tx, rx, col, lnk, dup} = 8'h0;
		addr = 5'h0;
		wd = 16'h0;
		{error_cnt, comparisons} = 0;
		seed = 32'hc92fa966;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd_chk(5'h14, 16'h0422);
		rd_chk(5'h03, 16'h0000);
		for (i = 0; i < 16; i = i + 1)
		begin
			seed = xs(seed);
			v = {8'h89, i[3:0], seed[3:2], i[0], 1'b0};
			{tx, rx, col} <= 3'h0;
			{lnk, dup, spd} <= seed[6:4];
			wr(v);
			repeat (80) @(posedge clk);
			{tx, rx, col} <= 3'h7;
			@(posedge clk);
			{tx, rx, col} <= 3'h0;
			rd_chk(5'h14, v & 16'hfffe);
			chk(lit[1:0], 2'h1);
			if (i == 8 || i == 9 || i == 15)
				chk(lit[2], i == 8);
			rnd_run(150);
		end
		{tx, rx, col} <= 3'h0;
		// Second pulse mid-window must restart the count
		for (i = 0; i < 4; i = i + 1)
		begin
			wr({8'h89, 4'h1, i[1:0], i != 3, 1'b0});
			n = 0;
			for (j = 0; j < 200; j = j + 1)
			begin
				@(posedge clk);
				tx <= j == 0 || j == 10;
				n = n + lit[2];
			end
			lo = i == 3 ? 2 : i == 2 ? C100 + 10 : i == 1 ? C60 + 10 : C30 + 10;
			chk(n >= lo && n <= lo + 2, 1'b1);
		end
		for (i = 10; i < 12; i = i + 1)
		begin
			wr({8'h89, i[3:0], 4'h2});
			b = lit[2];
			for (j = 0; j < 100 && lit[2] === b; j = j + 1)
				@(posedge clk);
			b = lit[2];
			for (n = 0; n < 100 && lit[2] === b; n = n + 1)
				@(posedge clk);
			lo = i == 10 ? CF : CS;
			chk(n >= lo - 1 && n <= lo + 1, 1'b1);
		end
		conclude;
	end
endmodule
